// *** hw/ipk_ctrl.sv ***
// four-channel peak/hold injector control with fault flags and registers
// assumes comparator inputs already synchronous to clk, one clock domain
// Function
// - four channels each start and end an event from their own command input.
// - an event starts in the peak phase regulating toward the high current target, or in hold when its peak time is zero.
// - after the peak time the channel holds at the low target until the command ends.
// - the peak time is taken from the host at a fixed refresh interval, latest value used.
// - if no current threshold was reached in an event, the open flag is set at its end.
// - reaching the peak level too fast after start sets the short flag and disables the channel.
// - later in the event an overcurrent also sets the short flag and disables the channel.
// - a disabled channel stays off until software clears it, not while its command is high.
// - low and high resistance loads use the same logic with no mode setting.
// - reaching the hold level in hold regulates current there.
`timescale 1ns/1ps
module ipk_ctrl #(
    parameter int unsigned REFRESH_CYC = ipk_pkg::REFRESH_CYC
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // sync reset, low active
    input wire logic [ipk_pkg::NCH-1:0] inj_cmd, // event commanded per channel
    input wire logic [ipk_pkg::NCH-1:0] peak_cmp, // current at peak target
    input wire logic [ipk_pkg::NCH-1:0] hold_cmp, // current at hold target
    input wire logic [ipk_pkg::NCH-1:0] short_cmp, // overcurrent comparator
    output logic [ipk_pkg::NCH-1:0] port_injector_driver, // switch on per channel
    input wire logic [ipk_pkg::AW-1:0] reg_addr, // register byte address
    input wire logic [ipk_pkg::DW-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [ipk_pkg::DW-1:0] reg_rdata, // read data, cycle after strobe
    output logic irq // level interrupt
);
    localparam int NCH = ipk_pkg::NCH;
    localparam int PW = ipk_pkg::PW;
    localparam int ECW = ipk_pkg::ECW;
    localparam int NEV = 2 * NCH;

    // true when the address hits one of the peak time words
    function automatic logic peak_hit(input logic [ipk_pkg::AW-1:0] a);
        logic [ipk_pkg::AW-1:0] d;
        d = a - ipk_pkg::OFS_PEAK0;
        return (a >= ipk_pkg::OFS_PEAK0) && (d < ipk_pkg::AW'(NCH * 4)) && (d[1:0] == 2'h0);
    endfunction

    // channel index of a peak time word
    function automatic logic [ipk_pkg::CIW-1:0] peak_index(input logic [ipk_pkg::AW-1:0] a);
        logic [ipk_pkg::AW-1:0] d;
        d = (a - ipk_pkg::OFS_PEAK0) / ipk_pkg::OFS_STRIDE;
        return d[ipk_pkg::CIW-1:0];
    endfunction

    ipk_tick_if tick_bus();

    // divider for the microsecond and refresh enables
    ipk_tick #(
        .REFRESH_CYC(REFRESH_CYC)
    ) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .tk(tick_bus)
    );

    logic [PW-1:0] peak_req_reg [NCH];
    logic [PW-1:0] peak_act_reg [NCH];
    logic [NCH-1:0] open_flag_reg;
    logic [NCH-1:0] short_flag_reg;
    logic [NEV-1:0] int_stat_reg;
    logic [NEV-1:0] int_en_reg;
    logic [NCH-1:0] open_evt;
    logic [NCH-1:0] short_evt;
    logic [NCH-1:0] in_peak;
    logic [NCH-1:0] drv_vec;
    logic [ipk_pkg::DW-1:0] rdata_reg;
    logic wr_flag_clr;
    logic wr_int_clr;
    logic [NCH-1:0] clr_open;
    logic [NCH-1:0] clr_short;
    logic [NEV-1:0] int_clr;
    logic [NEV-1:0] int_set;

    // write decode of the clear words
    assign wr_flag_clr = reg_wr && (reg_addr == ipk_pkg::OFS_FLAG_CLR);
    assign wr_int_clr = reg_wr && (reg_addr == ipk_pkg::OFS_INT_CLR);
    assign clr_open = wr_flag_clr ? reg_wdata[ipk_pkg::FLD_OPEN +: NCH] : '0;
    assign clr_short = wr_flag_clr ? (reg_wdata[ipk_pkg::FLD_SHORT +: NCH] & ~inj_cmd) : '0;
    assign int_clr = wr_int_clr ? reg_wdata[NEV-1:0] : '0;
    assign int_set = {short_evt, open_evt};

    // software side peak time words
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                peak_req_reg[i] <= ipk_pkg::PEAK_RST;
            end
        end else if (reg_wr && peak_hit(reg_addr)) begin
            peak_req_reg[peak_index(reg_addr)] <= reg_wdata[PW-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                peak_act_reg[i] <= ipk_pkg::PEAK_RST;
            end
        end else if (tick_bus.refresh_tick) begin
            for (int i = 0; i < NCH; i++) begin
                peak_act_reg[i] <= peak_req_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            open_flag_reg <= '0;
        end else begin
            open_flag_reg <= (open_flag_reg & ~clr_open) | open_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            short_flag_reg <= '0;
        end else begin
            short_flag_reg <= (short_flag_reg & ~clr_short) | short_evt;
        end
    end

    // interrupt status, an event in the clear cycle survives
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_stat_reg <= '0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
        end
    end

    // interrupt enable word
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_en_reg <= ipk_pkg::INT_EN_RST;
        end else if (reg_wr && (reg_addr == ipk_pkg::OFS_INT_EN)) begin
            int_en_reg <= reg_wdata[NEV-1:0];
        end
    end

    assign irq = |(int_stat_reg & int_en_reg);

    // read mux, unmapped and write-only words read zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= '0;
            if (peak_hit(reg_addr)) begin
                rdata_reg[PW-1:0] <= peak_req_reg[peak_index(reg_addr)];
            end else if (reg_addr == ipk_pkg::OFS_FLAGS) begin
                rdata_reg[ipk_pkg::FLD_OPEN +: NCH] <= open_flag_reg;
                rdata_reg[ipk_pkg::FLD_SHORT +: NCH] <= short_flag_reg;
                rdata_reg[ipk_pkg::FLD_PEAK +: NCH] <= in_peak;
                rdata_reg[ipk_pkg::FLD_DRV +: NCH] <= drv_vec;
            end else if (reg_addr == ipk_pkg::OFS_INT_STAT) begin
                rdata_reg[NEV-1:0] <= int_stat_reg;
            end else if (reg_addr == ipk_pkg::OFS_INT_EN) begin
                rdata_reg[NEV-1:0] <= int_en_reg;
            end
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;
    assign port_injector_driver = drv_vec;

    for (genvar g = 0; g < NCH; g++) begin : gen_ch
        ipk_pkg::ipk_state_e state_reg;
        ipk_pkg::ipk_state_e state_next;
        logic [ECW-1:0] ecnt_reg;
        logic [PW-1:0] pcnt_reg;
        logic seen_reg;
        logic cmd_q_reg;
        logic drv_reg;
        logic drv_next;
        logic start;
        logic active;
        logic early;
        logic short_hit;
        logic peak_done;

        // only a rising command starts, so a cleared fault never restarts mid-event
        assign start = (state_reg == ipk_pkg::ST_IDLE) && inj_cmd[g] && !cmd_q_reg
            && !short_flag_reg[g];
        assign active = (state_reg == ipk_pkg::ST_PEAK) || (state_reg == ipk_pkg::ST_HOLD);
        assign early = ecnt_reg < ipk_pkg::RISE_LIM;
        assign peak_done = pcnt_reg >= peak_act_reg[g];

        assign short_hit = active && inj_cmd[g]
            && ((early && peak_cmp[g]) || (!early && short_cmp[g]));
        assign short_evt[g] = short_hit;

        assign open_evt[g] = active && !inj_cmd[g] && !seen_reg && !peak_cmp[g]
            && !hold_cmp[g];

        // phase sequencing
        always_comb begin
            state_next = state_reg;
            case (state_reg)
                ipk_pkg::ST_IDLE: begin
                    if (start) begin
                        state_next = (peak_act_reg[g] == ipk_pkg::PEAK_RST) ?
                            ipk_pkg::ST_HOLD : ipk_pkg::ST_PEAK;
                    end
                end
                ipk_pkg::ST_PEAK: begin
                    if (!inj_cmd[g]) begin
                        state_next = ipk_pkg::ST_IDLE;
                    end else if (short_hit) begin
                        state_next = ipk_pkg::ST_FAULT;
                    end else if (peak_done) begin
                        state_next = ipk_pkg::ST_HOLD;
                    end
                end
                ipk_pkg::ST_HOLD: begin
                    if (!inj_cmd[g]) begin
                        state_next = ipk_pkg::ST_IDLE;
                    end else if (short_hit) begin
                        state_next = ipk_pkg::ST_FAULT;
                    end
                end
                ipk_pkg::ST_FAULT: begin
                    if (!inj_cmd[g]) begin
                        state_next = ipk_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_next = ipk_pkg::ST_IDLE;
                end
            endcase
        end

        // state and command history
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                state_reg <= ipk_pkg::ST_IDLE;
                cmd_q_reg <= 1'b0;
            end else begin
                state_reg <= state_next;
                cmd_q_reg <= inj_cmd[g];
            end
        end

        // peak timer in microseconds, first tick may land early by under 1 us
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                pcnt_reg <= '0;
            end else if (start) begin
                pcnt_reg <= '0;
            end else if ((state_reg == ipk_pkg::ST_PEAK) && tick_bus.us_tick && !peak_done) begin
                pcnt_reg <= pcnt_reg + 1'b1;
            end
        end

        // event age for the rise window, saturates at its limit
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                ecnt_reg <= '0;
            end else if (start) begin
                ecnt_reg <= '0;
            end else if (active && early) begin
                ecnt_reg <= ecnt_reg + 1'b1;
            end
        end

        // peak or hold threshold seen during the event
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                seen_reg <= 1'b0;
            end else if (start) begin
                seen_reg <= 1'b0;
            end else if (active && (peak_cmp[g] || hold_cmp[g])) begin
                seen_reg <= 1'b1;
            end
        end

        always_comb begin
            drv_next = 1'b0;
            if (state_next == ipk_pkg::ST_PEAK) begin
                drv_next = !peak_cmp[g];
            end else if (state_next == ipk_pkg::ST_HOLD) begin
                drv_next = !hold_cmp[g];
            end
            if (short_flag_reg[g] || short_hit) begin
                drv_next = 1'b0;
            end
        end

        // registered switch drive
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                drv_reg <= 1'b0;
            end else begin
                drv_reg <= drv_next;
            end
        end

        assign drv_vec[g] = drv_reg;
        assign in_peak[g] = (state_reg == ipk_pkg::ST_PEAK);
    end
endmodule

// *** hw/ipk_tick.sv ***
// divider making the 1 us and the peak refresh enable pulses
// assumes synchronous active-low reset on the single clock
`timescale 1ns/1ps
module ipk_tick #(
    parameter int unsigned REFRESH_CYC = ipk_pkg::REFRESH_CYC
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // sync reset, low active
    ipk_tick_if.src tk // enable pulses out
);
    localparam logic [ipk_pkg::RCW-1:0] RF_LAST = ipk_pkg::RCW'(REFRESH_CYC - 1);

    logic [ipk_pkg::USW-1:0] us_cnt_reg;
    logic [ipk_pkg::RCW-1:0] rf_cnt_reg;
    logic us_tick_reg;
    logic rf_tick_reg;

    // microsecond divider
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            us_cnt_reg <= '0;
            us_tick_reg <= 1'b0;
        end else if (us_cnt_reg == ipk_pkg::US_LAST) begin
            us_cnt_reg <= '0;
            us_tick_reg <= 1'b1;
        end else begin
            us_cnt_reg <= us_cnt_reg + 1'b1;
            us_tick_reg <= 1'b0;
        end
    end

    // refresh interval divider, free running
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rf_cnt_reg <= '0;
            rf_tick_reg <= 1'b0;
        end else if (rf_cnt_reg == RF_LAST) begin
            rf_cnt_reg <= '0;
            rf_tick_reg <= 1'b1;
        end else begin
            rf_cnt_reg <= rf_cnt_reg + 1'b1;
            rf_tick_reg <= 1'b0;
        end
    end

    assign tk.us_tick = us_tick_reg;
    assign tk.refresh_tick = rf_tick_reg;
endmodule

// *** shared/ipk_pkg.sv ***
// constants, register map and state codes of the injector channel block
// assumes one 100 MHz clock and a plain word-wide register port
package ipk_pkg;
    localparam int NCH = 4;
    localparam int CIW = 2;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int PW = 16;
    localparam int ECW = 12;
    localparam int USW = 7;
    localparam int RCW = 24;

    // timing, each figure in its own unit, cycle counts derived
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_PERIOD_NS;
    localparam int REFRESH_US = 125;
    localparam int REFRESH_CYC = REFRESH_US * US_NS / CLK_PERIOD_NS;
    localparam int SHORT_RISE_NS = 20000;
    localparam int SHORT_RISE_CYC = (SHORT_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [USW-1:0] US_LAST = USW'(US_CYC - 1);
    localparam logic [ECW-1:0] RISE_LIM = ECW'(SHORT_RISE_CYC);

    // register byte offsets
    localparam logic [AW-1:0] OFS_PEAK0 = 8'h00;
    localparam logic [AW-1:0] OFS_STRIDE = 8'h04;
    localparam logic [AW-1:0] OFS_FLAGS = 8'h10;
    localparam logic [AW-1:0] OFS_FLAG_CLR = 8'h14;
    localparam logic [AW-1:0] OFS_INT_STAT = 8'h18;
    localparam logic [AW-1:0] OFS_INT_CLR = 8'h1C;
    localparam logic [AW-1:0] OFS_INT_EN = 8'h20;

    // field positions inside flag and interrupt words
    localparam int FLD_OPEN = 0;
    localparam int FLD_SHORT = 4;
    localparam int FLD_PEAK = 8;
    localparam int FLD_DRV = 12;

    // reset values
    localparam logic [PW-1:0] PEAK_RST = 16'h0000;
    localparam logic [2*NCH-1:0] INT_EN_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PEAK = 4'h2,
        ST_HOLD = 4'h4,
        ST_FAULT = 4'h8
    } ipk_state_e;
endpackage

// *** shared/ipk_tick_if.sv ***
// timing enable pulses passed from the divider to the channel logic
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface ipk_tick_if;
    logic us_tick;
    logic refresh_tick;
    modport src (output us_tick, output refresh_tick);
    modport snk (input us_tick, input refresh_tick);
endinterface

// *** verif/ipk_ctrl_properties.sv ***
// port checker for the four-channel injector control
// assumes binding onto ipk_ctrl, one clock, sync active-low reset
`timescale 1ns/1ps
module ipk_ctrl_properties #(
    parameter int unsigned REFRESH_CYC = 12500
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // sync reset, low active
    input wire logic [ipk_pkg::NCH-1:0] inj_cmd, // commands
    input wire logic [ipk_pkg::NCH-1:0] peak_cmp, // peak level reached
    input wire logic [ipk_pkg::NCH-1:0] hold_cmp, // hold level reached
    input wire logic [ipk_pkg::NCH-1:0] short_cmp, // overcurrent
    input wire logic [ipk_pkg::NCH-1:0] port_injector_driver, // switches
    input wire logic reg_rd, // read strobe
    input wire logic [ipk_pkg::DW-1:0] reg_rdata, // read data
    input wire logic irq // interrupt level
);
    logic [11:0] ev_cnt_reg; // cycles since channel 0 command rose

    // saturates, so a long event never wraps back into the rise window
    always_ff @(posedge clk) begin
        if (!reset_n || !inj_cmd[0]) begin
            ev_cnt_reg <= 12'h000;
        end else if (ev_cnt_reg != 12'hFFF) begin
            ev_cnt_reg <= ev_cnt_reg + 12'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |=> port_injector_driver == 4'h0 && reg_rdata == 32'h0 && !irq)
        else $error("outputs not quiet after reset");
    a_drop_turns_off: assert property (
        (port_injector_driver & ~$past(inj_cmd)) == 4'h0)
        else $error("driver on without command");
    a_target_switch_off: assert property (
        (port_injector_driver & $past(peak_cmp & hold_cmp)) == 4'h0)
        else $error("driver on while target reached");
    a_rise_needs_cmd: assert property (
        $rose(port_injector_driver[0]) |-> $past(inj_cmd[0]))
        else $error("driver rose without command");
    a_drive_stays_on: assert property (
        inj_cmd[0] && port_injector_driver[0] && !(peak_cmp[0] | hold_cmp[0] | short_cmp[0])
        |=> port_injector_driver[0])
        else $error("driver dropped below target");
    a_rdata_one_cycle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_fast_rise_off: assert property (
        inj_cmd[0] && peak_cmp[0] && ev_cnt_reg >= 12'd2 && ev_cnt_reg <= 12'd1900
        |=> !port_injector_driver[0] [*3])
        else $error("fast rise did not disable");
    a_late_short_off: assert property (
        inj_cmd[0] && short_cmp[0] && ev_cnt_reg >= 12'd2100
        |=> !port_injector_driver[0] [*3])
        else $error("late short did not disable");

    c_irq: cover property ($rose(irq));
    c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0);
    c_late_short: cover property (inj_cmd[0] && short_cmp[0] && ev_cnt_reg >= 12'd2100);
endmodule

bind ipk_ctrl ipk_ctrl_properties #(.REFRESH_CYC(REFRESH_CYC)) i_ipk_ctrl_properties (
    .clk(clk), .reset_n(reset_n), .inj_cmd(inj_cmd), .peak_cmp(peak_cmp),
    .hold_cmp(hold_cmp), .short_cmp(short_cmp), .port_injector_driver(port_injector_driver),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// *** verif/ipk_host_model.sv ***
// host side model issuing per-channel injection commands
// assumes the bench pulses set and clear requests on the same clock
`timescale 1ns/1ps
module ipk_host_model (
    input wire logic clk, // system clock
    input wire logic reset_n, // sync reset, low active
    input wire logic [3:0] cmd_set, // start request per channel
    input wire logic [3:0] cmd_clr, // end request per channel
    output logic [3:0] inj_cmd // command level per channel
);
    // one clear per fault, zero peak and open flag ignored
    // for high resistance loads are kept by the register sequence
    // command level held per channel until its end request
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inj_cmd <= 4'h0;
        end else begin
            inj_cmd <= (inj_cmd | cmd_set) & ~cmd_clr;
        end
    end
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the injector channel control
// assumes REFRESH_CYC shortened to 20 cycles
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic reset_n;
    logic [3:0] cmd_set, cmd_clr, inj_cmd, peak_cmp, hold_cmp, short_cmp, drv;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, val;
    logic reg_wr, reg_rd, irq;
    int num_errors, comparisons, seed;
    logic [15:0] peak_q[$]; // expected peak words, in write order

    ipk_ctrl #(.REFRESH_CYC(20)) i_ipk_ctrl (.clk(clk), .reset_n(reset_n),
        .inj_cmd(inj_cmd), .peak_cmp(peak_cmp), .hold_cmp(hold_cmp), .short_cmp(short_cmp),
        .port_injector_driver(drv), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    ipk_host_model i_ipk_host_model (.clk(clk), .reset_n(reset_n), .cmd_set(cmd_set),
        .cmd_clr(cmd_clr), .inj_cmd(inj_cmd));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_drv(input logic [3:0] exp);
        @(negedge clk);
        comparisons++;
        if (drv !== exp) begin
            num_errors++;
            $display("[ERR] %0t drv got %h exp %h", $time, drv, exp);
        end
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        comparisons++;
        if (irq !== exp) begin
            num_errors++;
            $display("[ERR] %0t irq got %h exp %h", $time, irq, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk_reg(reg_rdata, exp);
    endtask

    task automatic cmd(input logic [3:0] s, input logic [3:0] c);
        @(posedge clk);
        cmd_set <= s;
        cmd_clr <= c;
        @(posedge clk);
        cmd_set <= 4'h0;
        cmd_clr <= 4'h0;
    endtask

    // a hang is cut short and counted
    initial begin
        cyc(30000);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        seed = 57;
        {num_errors, comparisons} = 0;
        {reset_n, reg_wr, reg_rd} = 3'h0;
        {cmd_set, cmd_clr, peak_cmp, hold_cmp, short_cmp} = 20'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        cyc(8);
        reset_n <= 1'b1;
        for (int a = 0; a < 'h48; a += 4) begin
            rd_chk(8'(a), 32'h0);
        end
        // all words written before any read back, so a stray write shows up
        for (int c = 0; c < 4; c++) begin
            val = $random(seed);
            wr(8'(c * 4), val);
            peak_q.push_back(val[15:0]);
        end
        for (int c = 0; c < 4; c++) begin
            rd_chk(8'(c * 4), {16'h0000, peak_q.pop_front()});
        end
        wr(8'h10, 32'hFFFFFFFF);
        rd_chk(8'h10, 32'h0);
        wr(8'h20, 32'hFF);
        rd_chk(8'h20, 32'hFF);
        $display("test registers done");

        // peak time shortened mid event, then hold regulation
        wr(8'h04, 32'd50);
        cyc(30);
        cmd(4'h2, 4'h0);
        cyc(500);
        wr(8'h04, 32'd30);
        rd_chk(8'h10, 32'h2200);
        cyc(1800);
        // comparator changes are seen one edge later, driver follows at that edge
        peak_cmp[1] <= 1'b1;
        cyc(1);
        chk_drv(4'h0);
        cyc(1);
        peak_cmp[1] <= 1'b0;
        cyc(1);
        chk_drv(4'h2);
        cyc(500);
        rd_chk(8'h10, 32'h2200);
        cyc(300);
        rd_chk(8'h10, 32'h2000);
        cyc(1);
        hold_cmp[1] <= 1'b1;
        cyc(1);
        chk_drv(4'h0);
        cyc(1);
        hold_cmp[1] <= 1'b0;
        cmd(4'h0, 4'h2);
        // the command level drops at the host edge, the design reacts one edge on
        cyc(1);
        chk_drv(4'h0);
        rd_chk(8'h10, 32'h0);
        $display("test peak hold done");

        // zero peak load never reaching a level, interrupt mask and clear
        wr(8'h08, 32'd0);
        cyc(30);
        cmd(4'h4, 4'h0);
        cyc(5);
        rd_chk(8'h10, 32'h4000);
        cyc(300);
        cmd(4'h0, 4'h4);
        cyc(2);
        rd_chk(8'h10, 32'h4);
        rd_chk(8'h18, 32'h4);
        chk_irq(1'b1);
        wr(8'h20, 32'hFB);
        chk_irq(1'b0);
        wr(8'h20, 32'hFF);
        chk_irq(1'b1);
        wr(8'h14, 32'h4);
        wr(8'h1C, 32'h4);
        rd_chk(8'h10, 32'h0);
        chk_irq(1'b0);
        $display("test open done");

        // fast rise, refused clear and restart, then a single clear
        wr(8'h00, 32'd40);
        cmd(4'h1, 4'h0);
        cyc(100);
        peak_cmp[0] <= 1'b1;
        cyc(1);
        peak_cmp[0] <= 1'b0;
        chk_drv(4'h0);
        rd_chk(8'h18, 32'h10);
        wr(8'h14, 32'h10);
        rd_chk(8'h10, 32'h10);
        cmd(4'h0, 4'h1);
        cmd(4'h1, 4'h0);
        cyc(5);
        chk_drv(4'h0);
        cmd(4'h0, 4'h1);
        wr(8'h14, 32'h10);
        wr(8'h1C, 32'h10);
        rd_chk(8'h10, 32'h0);
        $display("test fast rise done");

        // late short on one channel, neighbour keeps running
        wr(8'h0C, 32'd10);
        cyc(30);
        cmd(4'h9, 4'h0);
        cyc(2300);
        chk_drv(4'h9);
        cyc(1);
        short_cmp[0] <= 1'b1;
        cyc(1);
        short_cmp[0] <= 1'b0;
        chk_drv(4'h8);
        rd_chk(8'h10, 32'h8010);
        cmd(4'h0, 4'h9);
        cyc(2);
        rd_chk(8'h10, 32'h18);
        wr(8'h14, 32'hFF);
        wr(8'h1C, 32'hFF);
        rd_chk(8'h18, 32'h0);
        $display("test late short done");
        complete_run();
    end
endmodule
